// >>> hw/i2c_host_pkg.sv
package i2c_host_pkg;
	// device special-function bus map (8-bit addresses, 8-bit data)
	localparam logic [7:0] PORT3_ADDR = 8'hB0;
	localparam logic [7:0] PORT3_FUNC_ADDR = 8'h91;
	localparam logic [7:0] IRQ_ENABLE_EXT_ADDR = 8'hA7;
	localparam logic [7:0] IRQ_PRIORITY_EXT_ADDR = 8'hB7;
	localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'hDC;
	localparam logic [7:0] SERIAL_CONDITION_ADDR = 8'hDD;
	localparam logic [7:0] SERIAL_DATA_ADDR = 8'hDE;
	localparam logic [7:0] OWN_ADDRESS_ADDR = 8'hDF;
	localparam logic [7:0] BEGIN_FILTER_ADDR = 8'hDB;

	// device bit masks
	localparam logic [7:0] PORT3_LINE_MASK = 8'hC0;
	localparam logic [7:0] IRQ_SERIAL_MASK = 8'h02;
	localparam logic [7:0] CTL_UNIT_EN = 8'h40;
	localparam logic [7:0] CTL_BEGIN_REQ = 8'h20;
	localparam logic [7:0] CTL_HALT_REQ = 8'h10;
	localparam logic [7:0] CTL_OWN_MATCH = 8'h08;
	localparam logic [7:0] CTL_ACK_EN = 8'h80;
	localparam logic [7:0] ST_PENDING = 8'h10;
	localparam logic [7:0] ST_LINE_OCC = 8'h40;
	localparam logic [7:0] ST_ARB_FAIL = 8'h04;
	localparam logic [7:0] ST_PEER_ACK = 8'h02;
	localparam logic [7:0] ST_SEND_DIR = 8'h80;
	localparam logic [7:0] ST_HALT_SEEN = 8'h20;
	localparam logic [7:0] ADDR_WRITE_MASK = 8'hFE;
	localparam logic [7:0] ADDR_READ_FLAG = 8'h01;
	localparam logic [7:0] DUMMY_BYTE = 8'hFF;

	// wishbone register map (byte addresses)
	localparam logic [7:0] WB_CFG_OFS = 8'h00;
	localparam logic [7:0] WB_CMD_OFS = 8'h04;
	localparam logic [7:0] WB_STAT_OFS = 8'h08;
	localparam logic [1:0] WB_BUF_PAGE = 2'h1;
	localparam int BUF_DEPTH = 16;

	// configuration word fields
	localparam int CFG_FILT_LSB = 0;
	localparam int CFG_OWNA_LSB = 8;
	localparam int CFG_RATE_LSB = 16;
	localparam int CFG_PRIO_BIT = 19;
	localparam int CFG_SACK_BIT = 20;
	localparam logic [31:0] CFG_RESET = 32'h000000FF;

	// command word fields
	localparam int CMD_INIT_BIT = 0;
	localparam int CMD_GO_BIT = 1;
	localparam int CMD_MODE_LSB = 2;
	localparam int CMD_LEN_LSB = 8;
	localparam int CMD_TGT_LSB = 16;

	localparam logic [3:0] INIT_STEPS = 4'h8;

	typedef enum logic [1:0] {
		MODE_MTX = 2'b00,
		MODE_MRX = 2'b01,
		MODE_STX = 2'b10,
		MODE_SRX = 2'b11
	} mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} sfr_op_t;

	// one service step: control write before, data access, control after
	typedef struct packed {
		logic pre;
		logic post;
		logic dat_wr;
		logic [7:0] dat_val;
		logic store;
		logic inc;
		logic finish;
		logic [7:0] ctl_val;
		logic arb;
		logic nack;
		logic halt;
	} plan_t;
endpackage

// >>> hw/sync_2ff.sv
`timescale 1ns/100ps
module sync_2ff (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_r;
	logic q_r;

	// first stage is read only by the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			q_r <= 1'b0;
		end else begin
			meta_r <= d_i;
			q_r <= meta_r;
		end
	end

	assign q_o = q_r;
endmodule

// >>> hw/i2c_host.sv
// Functional notes
// - filter sample span stays just under START hold time per speed class
// - program bitrate select first, then the START sample count
// - typical filter setting FFh standard, 93h fast at 40 MHz
// - drive port3 pins 6,7 high then select their serial function
// - enable engine interrupt, optional priority, then load own address
// - wait line free, load address with direction bit, then request begin
// - master receiver clears acknowledge enable before last byte, then halts
// - service clears pending flag by writing 0, then reads status
// - own match with acknowledge enable marks address hit; clear by 0
// - slave transmitter writes dummy byte when master gives no ACK
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
module i2c_host
	import i2c_host_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [7:0] sfr_addr_o,
	output logic [7:0] sfr_wdata_o,
	output logic sfr_wr_o,
	output logic sfr_rd_o,
	input wire logic [7:0] sfr_rdata_i,
	input wire logic engine_irq_i
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ACC = 4'h1,
		ST_ACC_WAIT = 4'h2,
		ST_INIT = 4'h3,
		ST_SETUP = 4'h4,
		ST_POLL = 4'h5,
		ST_POLL_CHK = 4'h6,
		ST_BEGIN = 4'h7,
		ST_WAIT = 4'h8,
		ST_ISR_CLR = 4'h9,
		ST_ISR_STAT = 4'hA,
		ST_ISR_CTL = 4'hB,
		ST_PLAN = 4'hC,
		ST_DAT = 4'hD,
		ST_POST = 4'hE,
		ST_FINISH = 4'hF
	} state_t;

	state_t state_r, state_nxt, ret_r, iss_ret;
	sfr_op_t op_r, iss_op;
	plan_t plan_r, plan_nxt;
	mode_t mode_r;
	logic acc_wr_r, iss_wr, issue;
	logic [7:0] rd_r, stat_r, ctl_r;
	logic [31:0] cfg_r, cmd_r;
	logic [4:0] idx_r, len_r;
	logic [6:0] tgt_r;
	logic [3:0] init_step_r;
	logic first_r, req_init_r, req_go_r, done_r;
	logic arb_f_r, nack_f_r, halt_f_r;
	logic [31:0] wb_rdata_r;
	logic wb_ack_r;
	logic irq_sync;
	logic [7:0] buf_mem [BUF_DEPTH];

	// engine interrupt comes from another clock domain
	sync_2ff u_irq_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(engine_irq_i),
		.q_o(irq_sync)
	);

	// wishbone decode
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
	wire wb_wr = wb_req & wb_we_i;
	wire sel_cfg = wb_adr_i == WB_CFG_OFS;
	wire sel_cmd = wb_adr_i == WB_CMD_OFS;
	wire sel_stat = wb_adr_i == WB_STAT_OFS;
	wire sel_buf = wb_adr_i[7:6] == WB_BUF_PAGE;
	wire [31:0] lane_m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire busy = state_r != ST_IDLE;
	wire cmd_wr = wb_wr & sel_cmd & wb_sel_i[0];
	wire stat_clr = wb_wr & sel_stat & wb_sel_i[0] & wb_dat_i[1];
	wire [31:0] stat_word = {19'h00000, idx_r, 3'h0, halt_f_r, nack_f_r,
		arb_f_r, done_r, busy};
	wire [31:0] rdata_nxt = sel_cfg ? cfg_r :
		sel_cmd ? {cmd_r[31:2], 2'b00} :
		sel_stat ? stat_word :
		sel_buf ? {24'h000000, buf_mem[wb_adr_i[5:2]]} : 32'h00000000;

	// serial control value used for every transfer start
	wire [7:0] base_ctl = {5'h00, cfg_r[CFG_RATE_LSB +: 3]} | CTL_UNIT_EN;
	wire slave_mode = mode_r == MODE_STX || mode_r == MODE_SRX;
	wire [7:0] setup_ctl = (slave_mode && cfg_r[CFG_SACK_BIT]) ?
		(base_ctl | CTL_ACK_EN) : base_ctl;
	wire [7:0] addr_byte = (mode_r == MODE_MRX) ?
		({tgt_r, 1'b0} | ADDR_READ_FLAG) : ({tgt_r, 1'b0} & ADDR_WRITE_MASK);
	wire [7:0] idx_byte = buf_mem[idx_r[3:0]];
	wire room = idx_r < len_r;

	// bring-up writes, one per step
	function automatic sfr_op_t init_op(input logic [3:0] s,
		input logic [31:0] c);
		sfr_op_t o;
		o = {PORT3_ADDR, PORT3_LINE_MASK};
		unique case (s)
			4'h0: o = {PORT3_ADDR, PORT3_LINE_MASK};
			4'h1: o = {PORT3_FUNC_ADDR, PORT3_LINE_MASK};
			4'h2: o = {SERIAL_CONTROL_ADDR, 5'h00, c[CFG_RATE_LSB +: 3]};
			4'h3: o = {BEGIN_FILTER_ADDR, c[CFG_FILT_LSB +: 8]};
			4'h4: o = {IRQ_ENABLE_EXT_ADDR, IRQ_SERIAL_MASK};
			4'h5: o = {IRQ_PRIORITY_EXT_ADDR,
				c[CFG_PRIO_BIT] ? IRQ_SERIAL_MASK : 8'h00};
			4'h6: o = {OWN_ADDRESS_ADDR, c[CFG_OWNA_LSB +: 7], 1'b0};
			default: o = {SERIAL_CONTROL_ADDR, 5'h00, c[CFG_RATE_LSB +: 3]}
				| {8'h00, c[CFG_SACK_BIT] ? CTL_ACK_EN : 8'h00};
		endcase
		return o;
	endfunction

	// service decision from status (stat_r) and control readback (rd_r)
	always_comb begin
		logic arb, nack, stop, match, send;
		arb = (stat_r & ST_ARB_FAIL) != 8'h00;
		// peer acknowledge: 1 means no ACK
		nack = (stat_r & ST_PEER_ACK) != 8'h00;
		stop = (stat_r & ST_HALT_SEEN) != 8'h00;
		match = (rd_r & CTL_OWN_MATCH) != 8'h00 &&
			(rd_r & CTL_ACK_EN) != 8'h00;
		send = (stat_r & ST_SEND_DIR) != 8'h00;
		plan_nxt = '0;
		plan_nxt.dat_val = DUMMY_BYTE;
		plan_nxt.ctl_val = ctl_r;
		unique case (mode_r)
			MODE_MTX: begin
				plan_nxt.dat_wr = 1'b1;
				if (arb) begin
					// engine already turned slave; just release
					plan_nxt.arb = 1'b1;
					plan_nxt.finish = 1'b1;
				end else if (nack || !room) begin
					// halt set before the releasing write
					plan_nxt.ctl_val = ctl_r | CTL_HALT_REQ;
					plan_nxt.pre = 1'b1;
					plan_nxt.nack = nack;
					plan_nxt.finish = 1'b1;
				end else begin
					plan_nxt.dat_val = idx_byte;
					plan_nxt.inc = 1'b1;
				end
			end
			MODE_MRX: begin
				if (arb) begin
					plan_nxt.arb = 1'b1;
					plan_nxt.finish = 1'b1;
				end else if (first_r && nack) begin
					plan_nxt.ctl_val = ctl_r | CTL_HALT_REQ;
					plan_nxt.pre = 1'b1;
					plan_nxt.nack = 1'b1;
					plan_nxt.finish = 1'b1;
				end else if (first_r) begin
					// acknowledge only if more than one byte
					plan_nxt.pre = len_r > 5'h01;
					plan_nxt.ctl_val = plan_nxt.pre ? (ctl_r | CTL_ACK_EN) : ctl_r;
				end else begin
					plan_nxt.store = room;
					plan_nxt.inc = room;
					if (idx_r + 5'h01 >= len_r) begin
						// halt only after the last byte is read
						plan_nxt.ctl_val = ctl_r | CTL_HALT_REQ;
						plan_nxt.post = 1'b1;
						plan_nxt.finish = 1'b1;
					end else if (idx_r + 5'h02 == len_r) begin
						// no acknowledge for the final byte
						plan_nxt.ctl_val = ctl_r & ~CTL_ACK_EN;
						plan_nxt.pre = 1'b1;
					end
				end
			end
			default: begin
				if (stop) begin
					plan_nxt.halt = 1'b1;
					plan_nxt.finish = 1'b1;
					plan_nxt.dat_wr = mode_r == MODE_STX;
					plan_nxt.store = mode_r == MODE_SRX && room;
					plan_nxt.inc = plan_nxt.store;
				end else if (match) begin
					// write back with own match flag at 0
					plan_nxt.pre = 1'b1;
					plan_nxt.dat_wr = send;
					plan_nxt.dat_val = room ? idx_byte : DUMMY_BYTE;
					plan_nxt.inc = send && room;
				end else if (send) begin
					plan_nxt.dat_wr = 1'b1;
					// no ACK from master: dummy byte only
					plan_nxt.nack = nack;
					plan_nxt.finish = nack;
					plan_nxt.dat_val = (!nack && room) ? idx_byte : DUMMY_BYTE;
					plan_nxt.inc = !nack && room;
				end else begin
					plan_nxt.store = room;
					plan_nxt.inc = room;
				end
			end
		endcase
	end

	// sequencer: each step issues one device access, moves on, or holds (ST_IDLE without a request, ST_WAIT without interrupt)
	always_comb begin
		state_nxt = state_r;
		issue = 1'b0;
		iss_op = {SERIAL_DATA_ADDR, DUMMY_BYTE};
		iss_wr = 1'b1;
		iss_ret = ST_IDLE;
		unique case (state_r)
			ST_IDLE: begin
				if (req_init_r) begin
					state_nxt = ST_INIT;
				end else if (req_go_r) begin
					state_nxt = ST_SETUP;
				end
			end
			ST_ACC: state_nxt = ST_ACC_WAIT;
			ST_ACC_WAIT: state_nxt = ret_r;
			ST_INIT: begin
				if (init_step_r == INIT_STEPS) begin
					state_nxt = ST_FINISH;
				end else begin
					issue = 1'b1;
					iss_op = init_op(init_step_r, cfg_r);
					iss_ret = ST_INIT;
				end
			end
			ST_SETUP: begin
				issue = 1'b1;
				iss_op = {SERIAL_CONTROL_ADDR, setup_ctl};
				iss_ret = slave_mode ? ST_WAIT : ST_POLL;
			end
			// wait until the line is free
			ST_POLL: begin
				issue = 1'b1;
				iss_op = {SERIAL_CONDITION_ADDR, DUMMY_BYTE};
				iss_wr = 1'b0;
				iss_ret = ST_POLL_CHK;
			end
			ST_POLL_CHK: begin
				if ((rd_r & ST_LINE_OCC) != 8'h00) begin
					state_nxt = ST_POLL;
				end else begin
					issue = 1'b1;
					iss_op = {SERIAL_DATA_ADDR, addr_byte};
					iss_ret = ST_BEGIN;
				end
			end
			// begin request after the address byte
			ST_BEGIN: begin
				issue = 1'b1;
				iss_op = {SERIAL_CONTROL_ADDR, ctl_r | CTL_BEGIN_REQ};
				iss_ret = ST_WAIT;
			end
			ST_WAIT: begin
				if (irq_sync) begin
					issue = 1'b1;
					iss_op = {SERIAL_CONDITION_ADDR, DUMMY_BYTE};
					iss_wr = 1'b0;
					iss_ret = ST_ISR_CLR;
				end
			end
			// clear pending flag, then read the cause
			ST_ISR_CLR: begin
				issue = 1'b1;
				iss_op = {SERIAL_CONDITION_ADDR, rd_r & ~ST_PENDING};
				iss_ret = ST_ISR_STAT;
			end
			ST_ISR_STAT: begin
				issue = 1'b1;
				iss_op = {SERIAL_CONDITION_ADDR, DUMMY_BYTE};
				iss_wr = 1'b0;
				iss_ret = ST_ISR_CTL;
			end
			ST_ISR_CTL: begin
				issue = 1'b1;
				iss_op = {SERIAL_CONTROL_ADDR, DUMMY_BYTE};
				iss_wr = 1'b0;
				iss_ret = ST_PLAN;
			end
			ST_PLAN: begin
				if (plan_nxt.pre) begin
					issue = 1'b1;
					iss_op = {SERIAL_CONTROL_ADDR, plan_nxt.ctl_val};
					iss_ret = ST_DAT;
				end else begin
					state_nxt = ST_DAT;
				end
			end
			// this data access releases the held bus
			ST_DAT: begin
				issue = 1'b1;
				iss_op = {SERIAL_DATA_ADDR, plan_r.dat_val};
				iss_wr = plan_r.dat_wr;
				iss_ret = ST_POST;
			end
			ST_POST: begin
				if (plan_r.post) begin
					issue = 1'b1;
					iss_op = {SERIAL_CONTROL_ADDR, plan_r.ctl_val};
					iss_ret = plan_r.finish ? ST_FINISH : ST_WAIT;
				end else begin
					state_nxt = plan_r.finish ? ST_FINISH : ST_WAIT;
				end
			end
			ST_FINISH: state_nxt = ST_IDLE;
		endcase
		if (issue) begin
			state_nxt = ST_ACC;
		end
	end

	// sequencer state and device access registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			ret_r <= ST_IDLE;
			op_r <= '0;
			acc_wr_r <= 1'b0;
			rd_r <= 8'h00;
			stat_r <= 8'h00;
			plan_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (issue) begin
				ret_r <= iss_ret;
				op_r <= iss_op;
				acc_wr_r <= iss_wr;
			end
			// read data is valid the cycle after the strobe
			if (state_r == ST_ACC_WAIT && !acc_wr_r) begin
				rd_r <= sfr_rdata_i;
			end
			if (state_r == ST_ISR_CTL) begin
				stat_r <= rd_r;
			end
			if (state_r == ST_PLAN) begin
				plan_r <= plan_nxt;
			end
		end
	end

	// transfer bookkeeping and control shadow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_r <= 8'h00;
			idx_r <= 5'h00;
			len_r <= 5'h00;
			tgt_r <= 7'h00;
			mode_r <= MODE_MTX;
			first_r <= 1'b0;
			init_step_r <= 4'h0;
		end else begin
			if (state_r == ST_IDLE) begin
				init_step_r <= 4'h0;
				idx_r <= req_go_r ? 5'h00 : idx_r;
				first_r <= 1'b1;
				mode_r <= mode_t'(cmd_r[CMD_MODE_LSB +: 2]);
				len_r <= cmd_r[CMD_LEN_LSB +: 5];
				tgt_r <= cmd_r[CMD_TGT_LSB +: 7];
			end
			if (state_r == ST_INIT && issue) begin
				init_step_r <= init_step_r + 4'h1;
			end
			if (state_r == ST_SETUP) begin
				ctl_r <= setup_ctl;
			end
			if (state_r == ST_PLAN) begin
				ctl_r <= plan_nxt.ctl_val;
			end
			if (state_r == ST_POST && state_nxt != ST_ACC_WAIT) begin
				first_r <= 1'b0;
				idx_r <= plan_r.inc ? idx_r + 5'h01 : idx_r;
			end
		end
	end

	// captured bytes win over a bus write to the same cycle
	always_ff @(posedge clk_i) begin
		if (state_r == ST_POST && plan_r.store) begin
			buf_mem[idx_r[3:0]] <= rd_r;
		end else if (wb_wr && sel_buf && wb_sel_i[0]) begin
			buf_mem[wb_adr_i[5:2]] <= wb_dat_i[7:0];
		end
	end

	// software registers; commands while busy are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r <= CFG_RESET;
			cmd_r <= 32'h00000000;
			req_init_r <= 1'b0;
			req_go_r <= 1'b0;
			done_r <= 1'b0;
			arb_f_r <= 1'b0;
			nack_f_r <= 1'b0;
			halt_f_r <= 1'b0;
			wb_ack_r <= 1'b0;
			wb_rdata_r <= 32'h00000000;
		end else begin
			wb_ack_r <= wb_req;
			wb_rdata_r <= rdata_nxt;
			if (wb_wr && sel_cfg) begin
				cfg_r <= (cfg_r & ~lane_m) | (wb_dat_i & lane_m);
			end
			if (wb_wr && sel_cmd && !busy) begin
				cmd_r <= (cmd_r & ~lane_m) | (wb_dat_i & lane_m);
			end
			req_init_r <= (cmd_wr && !busy) ? wb_dat_i[CMD_INIT_BIT] :
				(state_r == ST_IDLE ? 1'b0 : req_init_r);
			req_go_r <= (cmd_wr && !busy) ? wb_dat_i[CMD_GO_BIT] :
				(state_r == ST_IDLE ? 1'b0 : req_go_r);
			// a finish in the clearing cycle keeps done set
			done_r <= (state_r == ST_FINISH) | (done_r & ~stat_clr);
			if (state_r == ST_SETUP) begin
				arb_f_r <= 1'b0;
				nack_f_r <= 1'b0;
				halt_f_r <= 1'b0;
			end else if (state_r == ST_POST && plan_r.finish) begin
				arb_f_r <= plan_r.arb;
				nack_f_r <= plan_r.nack;
				halt_f_r <= plan_r.halt;
			end
		end
	end

	assign wb_dat_o = wb_rdata_r;
	assign wb_ack_o = wb_ack_r;
	assign sfr_addr_o = op_r.addr;
	assign sfr_wdata_o = op_r.data;
	assign sfr_wr_o = state_r == ST_ACC && acc_wr_r;
	assign sfr_rd_o = state_r == ST_ACC && !acc_wr_r;
endmodule

// >>> tb/i2c_host_chk.sv
`timescale 1ns/100ps
module i2c_host_chk
	import i2c_host_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [7:0] sfr_addr_o,
	input wire logic [7:0] sfr_wdata_o,
	input wire logic sfr_wr_o,
	input wire logic sfr_rd_o,
	input wire logic [7:0] sfr_rdata_i,
	input wire logic engine_irq_i
);
	logic [7:0] lwa_r;
	logic [7:0] lwd_r;
	// last device write, so ordering rules can look one write back
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lwa_r <= 8'h00;
			lwd_r <= 8'h00;
		end else if (sfr_wr_o) begin
			lwa_r <= sfr_addr_o;
			lwd_r <= sfr_wdata_o;
		end
	end
	wire wr_ctl = sfr_wr_o && sfr_addr_o == SERIAL_CONTROL_ADDR;
	wire wr_dat = sfr_wr_o && sfr_addr_o == SERIAL_DATA_ADDR;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_begin;
		wr_ctl && sfr_wdata_o[5];
	endsequence
	a_wb_answer: assert property (s_take |=> wb_ack_o)
		else $error("wishbone ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("wishbone ack too long");
	a_strobe_gap: assert property ((sfr_wr_o || sfr_rd_o)
		|=> !(sfr_wr_o || sfr_rd_o))
		else $error("device accesses too close");
	// the pins must already be driven high when their function is switched
	a_pin_order: assert property (sfr_wr_o &&
		sfr_addr_o == PORT3_FUNC_ADDR |->
		lwa_r == PORT3_ADDR && lwd_r == PORT3_LINE_MASK)
		else $error("pin function set before pins high");
	a_rate_first: assert property (sfr_wr_o &&
		sfr_addr_o == BEGIN_FILTER_ADDR |-> lwa_r == SERIAL_CONTROL_ADDR)
		else $error("filter written before bitrate");
	a_addr_last: assert property (sfr_wr_o &&
		sfr_addr_o == OWN_ADDRESS_ADDR |-> lwa_r == IRQ_PRIORITY_EXT_ADDR)
		else $error("own address out of order");
	a_irq_on: assert property (sfr_wr_o &&
		sfr_addr_o == IRQ_ENABLE_EXT_ADDR |-> sfr_wdata_o[1])
		else $error("engine interrupt not enabled");
	a_begin_load: assert property (s_begin |->
		lwa_r == SERIAL_DATA_ADDR)
		else $error("begin without address load");
	a_pend_clear: assert property (sfr_wr_o &&
		sfr_addr_o == SERIAL_CONDITION_ADDR |-> !sfr_wdata_o[4])
		else $error("pending flag not cleared");
	a_dummy_byte: assert property (wr_dat &&
		lwa_r == SERIAL_CONTROL_ADDR && lwd_r[4] |->
		sfr_wdata_o == DUMMY_BYTE)
		else $error("release byte not dummy");
endmodule
bind i2c_host i2c_host_chk chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sfr_addr_o(sfr_addr_o),
	.sfr_wdata_o(sfr_wdata_o), .sfr_wr_o(sfr_wr_o), .sfr_rd_o(sfr_rd_o),
	.sfr_rdata_i(sfr_rdata_i), .engine_irq_i(engine_irq_i));

// >>> tb/engine_model.sv
`timescale 1ns/100ps
module engine_model
	import i2c_host_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	output logic engine_irq_o,
	input wire logic nack_i,
	input wire logic arb_i,
	input wire logic slave_i,
	input wire logic send_i
);
	logic [7:0] mem [0:255];
	logic [7:0] txlog [0:63];
	logic ackl [0:63];
	logic [7:0] st_r;
	logic act, slv, early;
	int tn, an, n, tmr, occ;
	wire [7:0] a = sfr_addr_i;
	wire wr_dat = sfr_wr_i && a == SERIAL_DATA_ADDR;
	wire rd_dat = sfr_rd_i && a == SERIAL_DATA_ADDR;
	wire wr_ctl = sfr_wr_i && a == SERIAL_CONTROL_ADDR;
	// START held for count plus one samples, one clock apart
	wire [7:0] smp = mem[BEGIN_FILTER_ADDR][7] ?
		mem[BEGIN_FILTER_ADDR] - 8'h7F : 8'h01;
	wire [7:0] stat = st_r | (occ != 0 ? ST_LINE_OCC : 8'h00);
	assign engine_irq_o = st_r[4] & mem[IRQ_ENABLE_EXT_ADDR][1];
	// bus events are fixed 40-cycle delays, slave START 40 plus the sample count, so speed limits go unchecked
	always @(posedge clk_i) begin
		if (rst_i) begin
			{st_r, act, slv, early} <= '0;
			{tn, an, n, tmr, occ} <= '0;
			sfr_rdata_o <= 8'h00;
		end else begin
			// read data stale outside a read: show the inverse
			sfr_rdata_o <= ~sfr_rdata_o;
			if (occ != 0)
				occ <= occ - 1;
			if (tmr != 0)
				tmr <= tmr - 1;
			if (sfr_rd_i)
				sfr_rdata_o <= a == SERIAL_CONDITION_ADDR ? stat : mem[a];
			if (sfr_wr_i)
				mem[a] <= sfr_wdata_i;
			if (sfr_wr_i && a == SERIAL_CONDITION_ADDR)
				st_r <= sfr_wdata_i;
			if (wr_dat) begin
				txlog[tn] <= sfr_wdata_i;
				tn <= tn + 1;
			end
			if (rd_dat) begin
				ackl[an] <= mem[SERIAL_CONTROL_ADDR][7];
				an <= an + 1;
			end
			// data access releases the held bus
			if ((wr_dat || rd_dat) && act && !mem[SERIAL_CONTROL_ADDR][4])
				tmr <= 40;
			if (wr_ctl && !act && sfr_wdata_i[6] && !sfr_wdata_i[5]) begin
				if (slave_i) begin
					{act, slv, n, tmr} <= {1'b1, 1'b1, 32'd0,
						32'd40 + 32'(smp)};
				end else
					occ <= 30;
			end
			if (wr_ctl && !act && sfr_wdata_i[5]) begin
				{act, slv, n, tmr} <= {1'b1, 1'b0, 32'd0, 32'd40};
				early <= early | (occ != 0);
			end
			if (wr_ctl && sfr_wdata_i[4]) begin
				act <= 1'b0;
				tmr <= 0;
			end
			if (tmr == 1) begin
				n <= n + 1;
				st_r[4] <= 1'b1;
				st_r[1] <= nack_i;
				st_r[2] <= arb_i && n == 0;
				st_r[5] <= slv && n == 3;
				st_r[7] <= slv && send_i;
				mem[SERIAL_DATA_ADDR] <= 8'hC0 + 8'(n);
				if (slv && n == 0 && mem[SERIAL_CONTROL_ADDR][7])
					mem[SERIAL_CONTROL_ADDR][3] <= 1'b1;
				if (slv && n == 3)
					act <= 1'b0;
			end
		end
	end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import i2c_host_pkg::*;
;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic nack = 0, arb = 0, slave = 0, send = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rd, st;
	wire [31:0] dat_o;
	wire ack, swr, srd, irq;
	wire [7:0] sa, swd, srdat;
	int fails = 0, compares = 0, cyc_n = 0, b, k;
	localparam logic [31:0] CFGV = 32'h001D2A93;
	logic [15:0] ini [7] = '{16'hB0C0, 16'h91C0, 16'hDC85, 16'hDB93,
		16'hA702, 16'hB702, 16'hDF54};
	i2c_host DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.sfr_addr_o(sa), .sfr_wdata_o(swd), .sfr_wr_o(swr),
		.sfr_rd_o(srd), .sfr_rdata_i(srdat), .engine_irq_i(irq));
	engine_model dev (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sa),
		.sfr_wdata_i(swd), .sfr_wr_i(swr), .sfr_rd_i(srd),
		.sfr_rdata_o(srdat), .engine_irq_o(irq), .nack_i(nack),
		.arb_i(arb), .slave_i(slave), .send_i(send));
	initial forever #10 clk_i = ~clk_i;
	task wrap_up;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// the ceiling sits well above the under two thousand cycles used
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 60000) begin
			fails++;
			wrap_up;
		end
	end
	task check(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// classic single cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		rd = dat_o;
		{cyc, stb, we} <= 3'b000;
	endtask
	// command, poll done under a bound, keep status, clear done
	task run(input logic [31:0] c);
		int i;
		wb(1'b1, WB_CMD_OFS, c);
		for (i = 0; i < 500; i++) begin
			wb(1'b0, WB_STAT_OFS, 32'h0);
			if (rd[1] === 1'b1)
				break;
		end
		if (i == 500) begin
			fails++;
			wrap_up;
		end
		st = rd;
		wb(1'b1, WB_STAT_OFS, 32'h2);
	endtask
	function automatic logic [31:0] cmd(input mode_t m, input logic [4:0] n);
		return {9'h0, 7'h35, 3'h0, n, 4'h0, m, 2'b10};
	endfunction
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, WB_CFG_OFS, 32'h0);
		check("cfg reset", CFG_RESET, rd);
		wb(1'b0, 8'h30, 32'h0);
		check("unmapped read", 32'h0, rd);
		wb(1'b1, WB_CFG_OFS, CFGV);
		wb(1'b0, WB_CFG_OFS, 32'h0);
		check("cfg", CFGV, rd);
		run(32'h1);
		for (k = 0; k < 7; k++)
			check("init reg", 32'(ini[k][7:0]), 32'(dev.mem[ini[k][15:8]]));
		wb(1'b0, WB_STAT_OFS, 32'h0);
		check("done cleared", 32'h0, 32'(rd[1]));
		// master transmit, two bytes acknowledged
		wb(1'b1, 8'h40, 32'h11);
		wb(1'b1, 8'h44, 32'h22);
		b = dev.tn;
		run(cmd(MODE_MTX, 5'd2));
		check("tx addr", 32'h6A, 32'(dev.txlog[b]));
		check("tx byte0", 32'h11, 32'(dev.txlog[b + 1]));
		check("tx byte1", 32'h22, 32'(dev.txlog[b + 2]));
		check("tx dummy", 32'hFF, 32'(dev.txlog[b + 3]));
		check("moved", 32'h2, 32'(st[12:8]));
		check("no ack flag", 32'h0, 32'(st[3]));
		check("begin on busy line", 32'h0, 32'(dev.early));
		// address not acknowledged: stop at once
		nack <= 1'b1;
		b = dev.tn;
		run(cmd(MODE_MTX, 5'd2));
		nack <= 1'b0;
		check("nack flag", 32'h1, 32'(st[3]));
		check("nack dummy", 32'hFF, 32'(dev.txlog[b + 1]));
		// master receive, three bytes, last one unacknowledged
		b = dev.an;
		k = dev.tn;
		run(cmd(MODE_MRX, 5'd3));
		check("rx addr", 32'h6B, 32'(dev.txlog[k]));
		check("ack 0", 32'h1, 32'(dev.ackl[b]));
		check("ack 1", 32'h1, 32'(dev.ackl[b + 1]));
		check("ack last", 32'h0, 32'(dev.ackl[b + 2]));
		for (k = 0; k < 3; k++) begin
			wb(1'b0, 8'h40 + 8'(4 * k), 32'h0);
			check("rx byte", 32'hC1 + k, 32'(rd[7:0]));
		end
		// slave receive, address match, two bytes, stop
		slave <= 1'b1;
		run(cmd(MODE_SRX, 5'd2));
		check("stop seen", 32'h1, 32'(st[4]));
		for (k = 0; k < 2; k++) begin
			wb(1'b0, 8'h40 + 8'(4 * k), 32'h0);
			check("slave byte", 32'hC1 + k, 32'(rd[7:0]));
		end
		// slave transmit: send direction on match, buffer runs dry, stop
		send <= 1'b1;
		b = dev.tn;
		run(cmd(MODE_STX, 5'd2));
		{slave, send} <= 2'b00;
		check("stx byte0", 32'hC1, 32'(dev.txlog[b]));
		check("stx byte1", 32'hC2, 32'(dev.txlog[b + 1]));
		check("stx spare", 32'hFF, 32'(dev.txlog[b + 2]));
		check("stx stop", 32'h1, 32'(st[4]));
		// arbitration lost on the address byte
		arb <= 1'b1;
		run(cmd(MODE_MTX, 5'd1));
		check("arb flag", 32'h1, 32'(st[2]));
		wrap_up;
	end
endmodule
